/* File: qec_pkg.sv */
// shared constants and carrier types for the quadrature encoder counter
package qec_pkg;
    localparam int CNT_W = 16;
    localparam int FLT_W = 4;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SMODE = 8'h04;
    localparam logic [7:0] OFS_CHEN = 8'h08;
    localparam logic [7:0] OFS_ARR = 8'h0C;
    localparam logic [7:0] OFS_CNT = 8'h10;
    localparam logic [7:0] OFS_IEN = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    localparam logic [7:0] OFS_EGR = 8'h1C;
    // control register fields
    localparam int CTRL_CEN = 0;
    localparam int CTRL_DIR = 4;
    localparam int CTRL_CMS_LO = 5;
    // channel enable register fields
    localparam int CHEN_POL_A = 1;
    localparam int CHEN_POL_B = 5;
    // slave mode field encodings
    localparam logic [2:0] SMS_ENC_B = 3'h1;
    localparam logic [2:0] SMS_ENC_A = 3'h2;
    localparam logic [2:0] SMS_ENC_AB = 3'h3;
    // event bit positions: update, ch1..ch3, trigger
    localparam int EV_UPD = 0;
    localparam int EV_CC1 = 1;
    localparam int EV_TRG = 4;
    localparam int EV_W = 5;
    // reset values
    localparam logic [CNT_W-1:0] ARR_RST = 16'hFFFF;
    localparam logic [FLT_W-1:0] FLT_RST = 4'h0;

    // one encoder step
    typedef struct packed {
        logic step;
        logic down;
        logic edge_seen;
    } qec_step_t;

    // filtered, polarity-corrected input pair
    typedef struct packed {
        logic a;
        logic b;
    } qec_pair_t;
endpackage

/* File: qec_filter.sv */
// input synchroniser, glitch filter and polarity select for one input
`timescale 1ns/10ps
module qec_filter (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // configuration
    input wire logic [qec_pkg::FLT_W-1:0] i_len,
    input wire logic i_invert,
    // pin and result
    input wire logic i_pin,
    output logic o_level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic stable;
        logic [qec_pkg::FLT_W-1:0] cnt;
        logic out;
    } qec_flt_state_t;

    qec_flt_state_t st_r;
    qec_flt_state_t st_nxt;

    // accept a new level only after it holds for i_len+1 cycles
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = i_pin;
        st_nxt.s2 = st_r.s1;
        if (st_r.s2 == st_r.stable)
        begin
            st_nxt.cnt = '0;
        end
        else if (st_r.cnt >= i_len)
        begin
            st_nxt.stable = st_r.s2;
            st_nxt.cnt = '0;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + 4'h1;
        end
        st_nxt.out = st_nxt.stable ^ i_invert;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign o_level = st_r.out;
endmodule // qec_filter

/* File: qec_decoder.sv */
// edge detector and direction decoder for the encoder pair
`timescale 1ns/10ps
module qec_decoder (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // inputs
    input wire logic [2:0] i_mode,
    input wire qec_pkg::qec_pair_t i_in,
    // result
    output qec_pkg::qec_step_t o_step
);
    typedef struct packed {
        qec_pkg::qec_pair_t prev;
        logic primed;
    } qec_dec_state_t;

    qec_dec_state_t st_r;
    qec_dec_state_t st_nxt;
    logic ea;
    logic eb;
    logic cnt_a;
    logic cnt_b;

    // one bit of history; first cycle after reset only primes it
    always_comb
    begin
        st_nxt.prev = i_in;
        st_nxt.primed = 1'b1;
        ea = st_r.primed && (i_in.a != st_r.prev.a);
        eb = st_r.primed && (i_in.b != st_r.prev.b);
        cnt_a = (i_mode == qec_pkg::SMS_ENC_A) ||
            (i_mode == qec_pkg::SMS_ENC_AB);
        cnt_b = (i_mode == qec_pkg::SMS_ENC_B) ||
            (i_mode == qec_pkg::SMS_ENC_AB);
        o_step.edge_seen = ea || eb;
        o_step.step = (ea && cnt_a) || (eb && cnt_b);
        // a rising with b high is down; b rising with a high is up
        if (ea)
            o_step.down = (i_in.a == i_in.b);
        else
            o_step.down = (i_in.a != i_in.b);
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
endmodule // qec_decoder

/* File: qec_top.sv */
// encoder interface counter with apb registers and interrupt logic
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/10ps
// How it works
// - slave mode 001, 010 or 011 selects encoder counting
// - two polarity bits invert inputs; programmable filter on both
// - single-input modes: direction from edge sense and other input level
// - both-edge mode counts every edge of either input, four per cycle
// - counting inputs are filtered and polarity-corrected raw inputs
// - with counter enable set, each valid transition moves count by one
// - direction comes from transition order and lands in direction bit
// - direction bit recomputed on any input transition in all three encoder modes
// - each count step leaves counter between zero and auto-reload value
// - other timer functions keep working; events still flagged
// - five interrupt sources: trigger, three channels, update
// - a source requests only while its enable bit is set
// - event generation register forces each source by software
// - direction bit read-only in center-aligned or encoder mode
module qec_top (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // encoder pins and channel events from the remaining timer logic
    input wire logic i_encoder_input_a,
    input wire logic i_encoder_input_b,
    input wire logic [2:0] i_cc_event,
    input wire logic i_trg_event,
    // status out
    output logic o_irq,
    output logic [qec_pkg::CNT_W-1:0] o_count
);
    typedef struct packed {
        logic counter_enable;
        logic dir;
        logic [1:0] cms;
        logic [2:0] slave_mode_select;
        logic [qec_pkg::FLT_W-1:0] flt_len;
        logic input1_polarity;
        logic input2_polarity;
        logic [qec_pkg::CNT_W-1:0] auto_reload_value;
        logic [qec_pkg::CNT_W-1:0] cnt;
        logic [qec_pkg::EV_W-1:0] irq_enable;
        logic [qec_pkg::EV_W-1:0] stat;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic irq;
    } qec_top_state_t;

    qec_top_state_t st_r;
    qec_top_state_t st_nxt;
    qec_pkg::qec_pair_t filt;
    qec_pkg::qec_step_t step;
    logic enc_mode;
    logic wr;
    logic rd;
    logic [qec_pkg::EV_W-1:0] ev;
    logic [qec_pkg::EV_W-1:0] forced;
    logic upd_hw;

    // decode of encoder mode, used for counting and dir lock
    function automatic logic is_enc(input logic [2:0] m);
        is_enc = (m == qec_pkg::SMS_ENC_A) || (m == qec_pkg::SMS_ENC_B)
            || (m == qec_pkg::SMS_ENC_AB);
    endfunction

    // filter both inputs with shared length, separate polarity
    qec_filter u_flt_a (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_len(st_r.flt_len),
        .i_invert(st_r.input1_polarity),
        .i_pin(i_encoder_input_a),
        .o_level(filt.a)
    );

    qec_filter u_flt_b (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_len(st_r.flt_len),
        .i_invert(st_r.input2_polarity),
        .i_pin(i_encoder_input_b),
        .o_level(filt.b)
    );

    qec_decoder u_dec (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_mode(st_r.slave_mode_select),
        .i_in(filt),
        .o_step(step)
    );

    // apb access phase; one wait state, write lands with ready
    always_comb
    begin
        wr = i_psel && i_penable && i_pwrite && st_r.ready;
        rd = i_psel && i_penable && !i_pwrite && !st_r.ready;
        enc_mode = is_enc(st_r.slave_mode_select);
        forced = '0;
        if (wr && i_paddr == qec_pkg::OFS_EGR)
            forced = i_pwdata[qec_pkg::EV_W-1:0];
    end

    // counter, registers and interrupt flags
    always_comb
    begin
        st_nxt = st_r;
        upd_hw = 1'b0;
        // direction follows transition order in any encoder mode
        if (enc_mode && step.edge_seen)
            st_nxt.dir = step.down;
        // counting only after software sets counter enable
        if (enc_mode && st_r.counter_enable && step.step)
        begin
            if (step.down)
            begin
                if (st_r.cnt == '0)
                begin
                    st_nxt.cnt = st_r.auto_reload_value;
                    upd_hw = 1'b1;
                end
                else if (st_r.cnt > st_r.auto_reload_value)
                    st_nxt.cnt = st_r.auto_reload_value;
                else
                    st_nxt.cnt = st_r.cnt - 16'h0001;
            end
            else
            begin
                if (st_r.cnt >= st_r.auto_reload_value)
                begin
                    st_nxt.cnt = '0;
                    upd_hw = 1'b1;
                end
                else
                    st_nxt.cnt = st_r.cnt + 16'h0001;
            end
        end
        // event sources; channel and trigger events pass through
        ev = forced;
        ev[qec_pkg::EV_UPD] = forced[qec_pkg::EV_UPD] | upd_hw;
        ev[qec_pkg::EV_CC1+2:qec_pkg::EV_CC1] =
            forced[qec_pkg::EV_CC1+2:qec_pkg::EV_CC1] | i_cc_event;
        ev[qec_pkg::EV_TRG] = forced[qec_pkg::EV_TRG] | i_trg_event;
        // register writes
        if (wr)
        begin
            case (i_paddr)
                qec_pkg::OFS_CTRL:
                begin
                    st_nxt.counter_enable = i_pwdata[qec_pkg::CTRL_CEN];
                    st_nxt.cms = i_pwdata[qec_pkg::CTRL_CMS_LO +: 2];
                    // software may not steer dir when hardware owns it
                    if (!enc_mode && st_r.cms == 2'h0)
                        st_nxt.dir = i_pwdata[qec_pkg::CTRL_DIR];
                end
                qec_pkg::OFS_SMODE:
                begin
                    st_nxt.slave_mode_select = i_pwdata[2:0];
                    st_nxt.flt_len = i_pwdata[7:4];
                end
                qec_pkg::OFS_CHEN:
                begin
                    st_nxt.input1_polarity = i_pwdata[qec_pkg::CHEN_POL_A];
                    st_nxt.input2_polarity = i_pwdata[qec_pkg::CHEN_POL_B];
                end
                qec_pkg::OFS_ARR:
                    st_nxt.auto_reload_value = i_pwdata[15:0];
                qec_pkg::OFS_CNT:
                    st_nxt.cnt = i_pwdata[15:0];
                qec_pkg::OFS_IEN:
                    st_nxt.irq_enable = i_pwdata[qec_pkg::EV_W-1:0];
                qec_pkg::OFS_STAT:
                    st_nxt.stat = st_r.stat & ~i_pwdata[qec_pkg::EV_W-1:0];
                default:
                    st_nxt.stat = st_nxt.stat;
            endcase
        end
        // set wins over the write-one clear above
        st_nxt.stat = st_nxt.stat | ev;
        // read mux
        st_nxt.rdata = '0;
        if (rd)
        begin
            case (i_paddr)
                qec_pkg::OFS_CTRL:
                    st_nxt.rdata = {25'h0, st_r.cms, st_r.dir,
                        3'h0, st_r.counter_enable};
                qec_pkg::OFS_SMODE:
                    st_nxt.rdata = {24'h0, st_r.flt_len, 1'b0,
                        st_r.slave_mode_select};
                qec_pkg::OFS_CHEN:
                    st_nxt.rdata = {26'h0, st_r.input2_polarity, 3'h0,
                        st_r.input1_polarity, 1'b0};
                qec_pkg::OFS_ARR:
                    st_nxt.rdata = {16'h0, st_r.auto_reload_value};
                qec_pkg::OFS_CNT:
                    st_nxt.rdata = {16'h0, st_r.cnt};
                qec_pkg::OFS_IEN:
                    st_nxt.rdata = {27'h0, st_r.irq_enable};
                qec_pkg::OFS_STAT:
                    st_nxt.rdata = {27'h0, st_r.stat};
                default:
                    st_nxt.rdata = '0;
            endcase
        end
        st_nxt.ready = i_psel && i_penable && !st_r.ready;
        st_nxt.slverr = i_psel && i_penable && !st_r.ready &&
            (i_paddr[1:0] != 2'h0 ||
            i_paddr > qec_pkg::OFS_EGR);
        // level interrupt from enabled sticky flags
        st_nxt.irq = |(st_nxt.stat & st_nxt.irq_enable);
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_r <= '0;
            st_r.auto_reload_value <= qec_pkg::ARR_RST;
            st_r.flt_len <= qec_pkg::FLT_RST;
        end
        else
            st_r <= st_nxt;
    end

    // outputs straight from flops
    assign o_prdata = st_r.rdata;
    assign o_pready = st_r.ready;
    assign o_pslverr = st_r.slverr;
    assign o_irq = st_r.irq;
    assign o_count = st_r.cnt;
endmodule // qec_top

/* File: qec_top_sva.sv */
// port assertions for the quadrature encoder counter
`timescale 1ns/10ps
module qec_top_sva (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // apb
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // encoder, events and status
    input wire logic i_encoder_input_a,
    input wire logic i_encoder_input_b,
    input wire logic [2:0] i_cc_event,
    input wire logic i_trg_event,
    input wire logic o_irq,
    input wire logic [qec_pkg::CNT_W-1:0] o_count
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    logic [3:0] quiet_r;
    // idle cycles since bus or pin activity; long enough to cover pipeline for filter lengths up to 9
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            quiet_r <= 4'h0;
        else if (i_psel || $changed(i_encoder_input_a)
                 || $changed(i_encoder_input_b))
            quiet_r <= 4'h0;
        else if (quiet_r != 4'hF)
            quiet_r <= quiet_r + 4'h1;
    end
    a_ready_wait: assert property (i_psel && !i_penable ##1
        i_psel && i_penable |=> o_pready)
        else $error("ready not one cycle after access");
    a_ready_once: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside ready");
    a_err_addr: assert property (o_pready && (i_paddr > 8'h1C
        || i_paddr[1:0] != 2'h0) |-> o_pslverr)
        else $error("bad address not refused");
    a_err_only_bad: assert property (o_pslverr |-> o_pready
        && (i_paddr > 8'h1C || i_paddr[1:0] != 2'h0))
        else $error("error on good address");
    a_stat_width: assert property (
        o_pready && !i_pwrite && i_paddr == qec_pkg::OFS_STAT
        |-> o_prdata[31:5] == 27'h0)
        else $error("status wider than five sources");
    a_egr_reads_zero: assert property (
        o_pready && i_paddr == qec_pkg::OFS_EGR |-> o_prdata == 32'h0)
        else $error("event register read not zero");
    a_count_unit: assert property (
        $changed(o_count) && !$past(i_psel) |->
        o_count == $past(o_count) + 16'h1
        || o_count == $past(o_count) - 16'h1
        || o_count == 16'h0 || $past(o_count) == 16'h0)
        else $error("counter moved by more than one");
    a_count_quiet: assert property (
        quiet_r >= 4'hC |=> $stable(o_count))
        else $error("counter moved without input edge");
    c_irq: cover property ($rose(o_irq));
    c_err: cover property (o_pslverr);
    c_wrap: cover property (o_count == 16'h0 && $past(o_count) != 16'h0);
endmodule // qec_top_sva

bind qec_top qec_top_sva qec_top_sva_inst (.i_ref_clk, .i_rst_n, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr, .i_encoder_input_a, .i_encoder_input_b, .i_cc_event,
    .i_trg_event, .o_irq, .o_count);

/* File: qec_enc_model.sv */
// incremental quadrature encoder model driving the two pins
`timescale 1ns/10ps
module qec_enc_model (
    // clock
    input wire logic i_ref_clk,
    // step request
    input wire logic i_step,
    input wire logic i_back,
    // pins
    output logic o_a,
    output logic o_b
);
    logic [1:0] ph_r = 2'h0;
    // gray phase; forward has input a leading input b
    always_ff @(posedge i_ref_clk)
    begin
        if (i_step)
            ph_r <= i_back ? ph_r - 2'h1 : ph_r + 2'h1;
    end
    assign o_a = ph_r[1] ^ ph_r[0];
    assign o_b = ph_r[1];
endmodule // qec_enc_model

/* File: test_quadrature_encoder_counter.sv */
// self-checking bench for the quadrature encoder counter
`timescale 1ns/10ps
module test_quadrature_encoder_counter;
    typedef struct packed {
        logic [2:0] md;
        logic [7:0] pol;
        logic bk;
        logic [15:0] cnt;
    } qec_row_t;
    logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0;
    logic i_penable = 1'b0, i_pwrite = 1'b0, i_trg_event = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
    logic [2:0] i_cc_event = 3'h0;
    logic o_pready, o_pslverr, o_irq, i_encoder_input_a, i_encoder_input_b;
    logic step = 1'b0, back = 1'b0, rerr;
    logic [15:0] o_count;
    int err_total = 0, compares = 0;
    qec_row_t rows [10] = '{
        '{3'h1, 8'h00, 1'b0, 16'h0104}, '{3'h1, 8'h00, 1'b1, 16'h00FC},
        '{3'h2, 8'h00, 1'b0, 16'h0104}, '{3'h2, 8'h00, 1'b1, 16'h00FC},
        '{3'h3, 8'h00, 1'b0, 16'h0108}, '{3'h3, 8'h00, 1'b1, 16'h00F8},
        '{3'h3, 8'h02, 1'b0, 16'h00F8}, '{3'h3, 8'h20, 1'b0, 16'h00F8},
        '{3'h3, 8'h22, 1'b0, 16'h0108}, '{3'h0, 8'h00, 1'b0, 16'h0100}};

    qec_top qec_top_inst (.i_ref_clk, .i_rst_n, .i_psel, .i_penable,
        .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
        .i_encoder_input_a, .i_encoder_input_b, .i_cc_event, .i_trg_event,
        .o_irq, .o_count);
    qec_enc_model qec_enc_model_inst (.i_ref_clk, .i_step(step),
        .i_back(back), .o_a(i_encoder_input_a), .o_b(i_encoder_input_b));

    always #5 i_ref_clk = ~i_ref_clk;

    task automatic cmp(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s exp %h got %h", what, e, g);
        end
    endtask
    // one apb transfer; waits for ready under a bound
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        do
        begin
            @(posedge i_ref_clk);
            n++;
        end
        while (o_pready !== 1'b1 && n < 20);
        rd = o_prdata;
        rerr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        // idle edge so a following call never reassigns in this step
        @(posedge i_ref_clk);
        if (n == 20)
            err_total++;
    endtask
    // encoder steps, spaced past the input pipeline
    task automatic mv(input logic b, input int n);
        repeat (n)
        begin
            step <= 1'b1;
            back <= b;
            @(posedge i_ref_clk);
            step <= 1'b0;
            repeat (8) @(posedge i_ref_clk);
        end
    endtask
    task automatic conclude;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (50000) @(posedge i_ref_clk);
        err_total++;
        conclude();
    end

    initial
    begin
        repeat (10) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        @(posedge i_ref_clk);
        apb(1'b0, qec_pkg::OFS_ARR, 32'h0);
        cmp("arr reset", 32'h0000FFFF, rd);
        apb(1'b0, qec_pkg::OFS_STAT, 32'h0);
        cmp("stat reset", 32'h0, rd);
        cmp("irq reset", 32'h0, {31'h0, o_irq});
        // counter off while mode and polarity change, so no count
        foreach (rows[i])
        begin
            apb(1'b1, qec_pkg::OFS_CTRL, 32'h0);
            apb(1'b1, qec_pkg::OFS_SMODE, {29'h0, rows[i].md});
            apb(1'b1, qec_pkg::OFS_CHEN, {24'h0, rows[i].pol});
            repeat (12) @(posedge i_ref_clk);
            apb(1'b1, qec_pkg::OFS_CNT, 32'h00000100);
            apb(1'b1, qec_pkg::OFS_CTRL, 32'h00000001);
            mv(rows[i].bk, 8);
            apb(1'b0, qec_pkg::OFS_CNT, 32'h0);
            cmp("count", {16'h0, rows[i].cnt}, rd);
            apb(1'b0, qec_pkg::OFS_CTRL, 32'h0);
            cmp("dir", {31'h0, rows[i].cnt < 16'h0100}, {31'h0, rd[4]});
        end
        // wrap at a small reload, reload set before enable
        apb(1'b1, qec_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, qec_pkg::OFS_SMODE, 32'h00000003);
        apb(1'b1, qec_pkg::OFS_ARR, 32'h00000005);
        apb(1'b1, qec_pkg::OFS_CNT, 32'h00000004);
        apb(1'b1, qec_pkg::OFS_STAT, 32'h0000001F);
        apb(1'b1, qec_pkg::OFS_IEN, 32'h00000001);
        apb(1'b1, qec_pkg::OFS_CTRL, 32'h00000001);
        mv(1'b0, 2);
        apb(1'b0, qec_pkg::OFS_CNT, 32'h0);
        cmp("wrap up", 32'h0, rd);
        apb(1'b0, qec_pkg::OFS_STAT, 32'h0);
        cmp("update flag", 32'h00000001, rd);
        cmp("irq on", 32'h1, {31'h0, o_irq});
        mv(1'b1, 1);
        apb(1'b0, qec_pkg::OFS_CNT, 32'h0);
        cmp("wrap down", 32'h00000005, rd);
        apb(1'b1, qec_pkg::OFS_CTRL, 32'h00000001);
        apb(1'b0, qec_pkg::OFS_CTRL, 32'h0);
        cmp("dir held", 32'h1, {31'h0, rd[4]});
        apb(1'b1, qec_pkg::OFS_IEN, 32'h0);
        repeat (2) @(posedge i_ref_clk);
        cmp("irq masked", 32'h0, {31'h0, o_irq});
        apb(1'b1, qec_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, qec_pkg::OFS_STAT, 32'h00000001);
        apb(1'b0, qec_pkg::OFS_STAT, 32'h0);
        cmp("cleared", 32'h0, rd);
        apb(1'b1, qec_pkg::OFS_EGR, 32'h0000001F);
        apb(1'b0, qec_pkg::OFS_STAT, 32'h0);
        cmp("forced", 32'h0000001F, rd);
        apb(1'b1, qec_pkg::OFS_IEN, 32'h00000010);
        repeat (2) @(posedge i_ref_clk);
        cmp("irq trig", 32'h1, {31'h0, o_irq});
        apb(1'b1, qec_pkg::OFS_STAT, 32'h0000001F);
        i_cc_event <= 3'h7;
        i_trg_event <= 1'b1;
        @(posedge i_ref_clk);
        i_cc_event <= 3'h0;
        i_trg_event <= 1'b0;
        apb(1'b0, qec_pkg::OFS_STAT, 32'h0);
        cmp("events", 32'h0000001E, rd);
        apb(1'b0, 8'h20, 32'h0);
        cmp("unmapped", 32'h1, {31'h0, rerr});
        cmp("unmapped data", 32'h0, rd);
        conclude();
    end
endmodule // test_quadrature_encoder_counter
